// [hw/fdo_pkg.sv]
package fdo_pkg;

   // Clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_MIN_US = 100;
   localparam int TICK_MIN_CYC = (TICK_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int TICK_HALF_CYC = TICK_MIN_CYC / 2;
   localparam int PW_MAX_MS = 50;
   localparam int PW_MAX_CYC = PW_MAX_MS * (CLK_HZ / 1000);
   localparam int RATE_FULL_LOG2 = 16;
   localparam logic [47:0] FREQ_HALF_THR = 48'(CLK_HZ) * (48'h1 << (RATE_FULL_LOG2 - 1));

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ALARM_EN = 8'h04;
   localparam logic [7:0] REG_UNITS = 8'h08;
   localparam logic [7:0] REG_UPPER_FREQ = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_PULSE_TOTAL = 8'h14;

   // Reset values
   localparam logic [13:0] CTRL_RST = 14'h0000;
   localparam logic [7:0] ALARM_EN_RST = 8'h00;
   localparam logic [15:0] UNITS_RST = 16'h0001;
   localparam logic [15:0] UPPER_FREQ_RST = 16'h03e8;

   // Status field positions
   localparam int ST_DOUT = 0;
   localparam int ST_REVERSE = 1;
   localparam int ST_ALARM = 2;
   localparam int ST_BIN_LEVEL = 3;
   localparam int ST_PULSE_BUSY = 4;
   localparam int ST_PENDING_LSB = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {MODE_OFF = 2'b00, MODE_BINARY = 2'b01, MODE_PULSE = 2'b10, MODE_FREQ = 2'b11} fdo_mode_t;
   typedef enum logic [1:0] {DIR_BOTH = 2'b00, DIR_FWD = 2'b01, DIR_REV = 2'b10, DIR_RSVD = 2'b11} fdo_dir_t;
   typedef enum logic [1:0] {SRC_OFF = 2'b00, SRC_MASS = 2'b01, SRC_VOLUME = 2'b10, SRC_RSVD = 2'b11} fdo_src_t;
   typedef enum logic [2:0] {FN_OFF = 3'b000, FN_DIRECTION = 3'b001, FN_ALARM = 3'b010, FN_RANGE = 3'b011,
                             FN_BATCH = 3'b100} fdo_fn_t;
   typedef enum logic [1:0] {P_IDLE = 2'b00, P_HIGH = 2'b01, P_GAP = 2'b10} fdo_pstate_t;

   typedef struct packed {
      logic batch_en;
      logic dual_range;
      logic pol_low;
      fdo_fn_t fn;
      fdo_src_t freq_src;
      fdo_src_t pulse_src;
      fdo_dir_t dir;
      fdo_mode_t mode;
   } fdo_ctrl_t;

   typedef struct packed {
      logic internal_temp;
      logic sensor_temp;
      logic conductivity;
      logic gas_bubble;
      logic partial_fill_alarm;
      logic empty_tube_alarm;
      logic volume_flow_low_alarm;
      logic volume_flow_high_alarm;
   } fdo_alarm_t;

endpackage

// [hw/fdo_top.sv]
// What this block does
// - Four modes: off, binary, pulse, frequency; exactly one active.
// - Pulse mode emits one pulse per configured units-per-pulse of quantity.
// - Frequency mode output frequency scales linearly with flow rate.
// - Upper frequency value is the output frequency at full-scale flow.
// - Both-directions filter passes flow of either direction.
// - Forward filter passes only forward flow.
// - Reverse filter passes only reverse flow.
// - Direction filter applies only in pulse and frequency modes.
// - Pulse source selects off, mass or volume; off gives no pulses.
// - Frequency source selects off, mass or volume flow rate.
// - Pulse width is derived from units-per-pulse, not fixed.
// - Binary direction function shows current flow direction.
// - Binary alarm function asserts while any enabled alarm is active.
// - Binary range function asserts in range two, only if dual ranging set.
// - Binary batch function asserts at fill quantity, only if batching enabled.
// - Binary polarity active high or low, default active high.
// - Eight alarm enables exist, used only by the alarm function.
// - Pulse, frequency and binary settings act only in their own mode.
// - Empty-tube alarm source means tube detected empty.
// - Partial-fill alarm source means tube detected partly filled.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fdo_top #(
   parameter int PW_MAX_CYC = fdo_pkg::PW_MAX_CYC,
   parameter int TICK_HALF_CYC = fdo_pkg::TICK_HALF_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Measurement inputs, same clock
   input wire logic [15:0] mass_rate,
   input wire logic [15:0] volume_rate,
   input wire logic mass_tick,
   input wire logic volume_tick,
   input wire logic flow_reverse,
   input wire fdo_pkg::fdo_alarm_t alarm_src,
   input wire logic range_two_active,
   input wire logic fill_reached,
   // Terminal output
   output logic dout
);

   initial begin
      if (PW_MAX_CYC < 1 || TICK_HALF_CYC < 1 || TICK_HALF_CYC > 65535) begin
         $error("bad pulse timing parameters");
      end
   end

   // One-hot hit; bit 6 flags an unmapped address
   function automatic logic [6:0] reg_decode(input logic [7:0] addr);
      logic [6:0] hit;
      hit = 7'h00;
      unique case (addr)
         fdo_pkg::REG_CTRL: hit[0] = 1'b1;
         fdo_pkg::REG_ALARM_EN: hit[1] = 1'b1;
         fdo_pkg::REG_UNITS: hit[2] = 1'b1;
         fdo_pkg::REG_UPPER_FREQ: hit[3] = 1'b1;
         fdo_pkg::REG_STATUS: hit[4] = 1'b1;
         fdo_pkg::REG_PULSE_TOTAL: hit[5] = 1'b1;
         default: hit[6] = 1'b1;
      endcase
      return hit;
   endfunction

   function automatic logic dir_pass(input fdo_pkg::fdo_dir_t dir, input logic rev);
      return (dir == fdo_pkg::DIR_FWD) ? !rev
           : (dir == fdo_pkg::DIR_REV) ? rev : 1'b1;
   endfunction

   // Registers
   fdo_pkg::fdo_ctrl_t ctrl_reg;
   logic [7:0] alarm_en_reg;
   logic [15:0] units_reg;
   logic [15:0] upper_freq_reg;
   logic [31:0] pulse_total_reg;

   // Bus state
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic dout_reg;

   logic do_write;
   logic [6:0] wr_hit;
   logic [6:0] rd_hit;

   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_hit = reg_decode(awaddr_reg);
   assign rd_hit = reg_decode(s_axi_araddr);

   // Byte lanes with a clear strobe keep their old bits
   logic [31:0] wmask;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         awready_reg <= 1'b0;
      end else if (s_axi_awvalid && awready_reg) begin
         aw_hold_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr;
         awready_reg <= 1'b0;
      end else if (do_write) begin
         aw_hold_reg <= 1'b0;
      end else if (!aw_hold_reg && !bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         w_hold_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         wready_reg <= 1'b0;
      end else if (s_axi_wvalid && wready_reg) begin
         w_hold_reg <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
         wready_reg <= 1'b0;
      end else if (do_write) begin
         w_hold_reg <= 1'b0;
      end else if (!w_hold_reg && !bvalid_reg) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= fdo_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_hit[6] || wr_hit[4] || wr_hit[5]) ? fdo_pkg::RESP_SLVERR : fdo_pkg::RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Writable configuration
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_reg <= fdo_pkg::fdo_ctrl_t'(fdo_pkg::CTRL_RST);
         alarm_en_reg <= fdo_pkg::ALARM_EN_RST;
         units_reg <= fdo_pkg::UNITS_RST;
         upper_freq_reg <= fdo_pkg::UPPER_FREQ_RST;
      end else if (do_write) begin
         if (wr_hit[0]) begin
            ctrl_reg <= fdo_pkg::fdo_ctrl_t'((ctrl_reg & ~wmask[13:0]) | (wdata_reg[13:0] & wmask[13:0]));
         end
         if (wr_hit[1]) begin
            alarm_en_reg <= (alarm_en_reg & ~wmask[7:0]) | (wdata_reg[7:0] & wmask[7:0]);
         end
         if (wr_hit[2]) begin
            units_reg <= (units_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
         end
         if (wr_hit[3]) begin
            upper_freq_reg <= (upper_freq_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
         end
      end
   end

   // Binary function
   logic alarm_any;
   logic fn_level;
   logic bin_level;

   // Sources arrive qualified upstream
   assign alarm_any = |(alarm_src & alarm_en_reg);

   always_comb begin
      fn_level = 1'b0;
      case (ctrl_reg.fn)
         fdo_pkg::FN_DIRECTION: fn_level = flow_reverse;
         fdo_pkg::FN_ALARM: fn_level = alarm_any;
         fdo_pkg::FN_RANGE: fn_level = ctrl_reg.dual_range && range_two_active;
         fdo_pkg::FN_BATCH: fn_level = ctrl_reg.batch_en && fill_reached;
         default: fn_level = 1'b0;
      endcase
   end

   assign bin_level = fn_level ^ ctrl_reg.pol_low;

   // Pulse engine
   logic pulse_cfg_on;
   logic tick_sel;
   logic tick_ok;
   logic [15:0] units_eff;
   logic unit_hit;
   logic [15:0] qty_cnt_reg;
   logic [7:0] pending_reg;
   logic pulse_start;
   logic [31:0] pw_full;
   logic [31:0] pw_cyc;
   logic [31:0] pw_cnt_reg;
   fdo_pkg::fdo_pstate_t pstate_reg;

   // Pulse state clears outside pulse mode
   assign pulse_cfg_on = (ctrl_reg.mode == fdo_pkg::MODE_PULSE);

   always_comb begin
      tick_sel = 1'b0;
      case (ctrl_reg.pulse_src)
         fdo_pkg::SRC_MASS: tick_sel = mass_tick;
         fdo_pkg::SRC_VOLUME: tick_sel = volume_tick;
         default: tick_sel = 1'b0;
      endcase
   end

   assign tick_ok = pulse_cfg_on && tick_sel && dir_pass(ctrl_reg.dir, flow_reverse);
   assign units_eff = (units_reg == 16'h0000) ? 16'h0001 : units_reg;
   assign unit_hit = tick_ok && (({1'b0, qty_cnt_reg} + 17'h00001) >= {1'b0, units_eff});

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !pulse_cfg_on) begin
         qty_cnt_reg <= 16'h0000;
      end else if (unit_hit) begin
         qty_cnt_reg <= 16'h0000;
      end else if (tick_ok) begin
         qty_cnt_reg <= qty_cnt_reg + 16'h0001;
      end
   end

   // Width scales with units per pulse so back-to-back pulses never merge at top rate
   assign pw_full = 32'(units_eff) * 32'(TICK_HALF_CYC);
   assign pw_cyc = (pw_full > 32'(PW_MAX_CYC)) ? 32'(PW_MAX_CYC) : pw_full;
   assign pulse_start = (pstate_reg == fdo_pkg::P_IDLE) && (pending_reg != 8'h00);

   // A hit in the same cycle as a start keeps the count: the new pulse is not lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !pulse_cfg_on) begin
         pending_reg <= 8'h00;
      end else if (unit_hit && !pulse_start) begin
         pending_reg <= (pending_reg == 8'hff) ? pending_reg : pending_reg + 8'h01;
      end else if (pulse_start && !unit_hit) begin
         pending_reg <= pending_reg - 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !pulse_cfg_on) begin
         pstate_reg <= fdo_pkg::P_IDLE;
         pw_cnt_reg <= 32'h0000_0000;
      end else begin
         unique case (pstate_reg)
            fdo_pkg::P_IDLE: begin
               if (pulse_start) begin
                  pstate_reg <= fdo_pkg::P_HIGH;
                  pw_cnt_reg <= pw_cyc - 32'h1;
               end
            end
            fdo_pkg::P_HIGH: begin
               if (pw_cnt_reg == 32'h0) begin
                  pstate_reg <= fdo_pkg::P_GAP;
                  pw_cnt_reg <= pw_cyc - 32'h1;
               end else begin
                  pw_cnt_reg <= pw_cnt_reg - 32'h1;
               end
            end
            fdo_pkg::P_GAP: begin
               if (pw_cnt_reg == 32'h0) begin
                  pstate_reg <= fdo_pkg::P_IDLE;
               end else begin
                  pw_cnt_reg <= pw_cnt_reg - 32'h1;
               end
            end
            default: begin
               pstate_reg <= fdo_pkg::P_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pulse_total_reg <= 32'h0000_0000;
      end else if (pulse_start) begin
         pulse_total_reg <= pulse_total_reg + 32'h1;
      end
   end

   // Frequency engine
   logic freq_cfg_on;
   logic [15:0] rate_sel;
   logic [47:0] freq_inc;
   logic [47:0] freq_sum;
   logic [47:0] freq_acc_reg;
   logic freq_lvl_reg;

   assign freq_cfg_on = (ctrl_reg.mode == fdo_pkg::MODE_FREQ);

   always_comb begin
      rate_sel = 16'h0000;
      case (ctrl_reg.freq_src)
         fdo_pkg::SRC_MASS: rate_sel = mass_rate;
         fdo_pkg::SRC_VOLUME: rate_sel = volume_rate;
         default: rate_sel = 16'h0000;
      endcase
      if (!dir_pass(ctrl_reg.dir, flow_reverse)) begin
         rate_sel = 16'h0000;
      end
   end

   // Step is upper frequency x rate; full scale 2^16
   assign freq_inc = 48'(upper_freq_reg) * 48'(rate_sel);
   assign freq_sum = freq_acc_reg + freq_inc;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || !freq_cfg_on) begin
         freq_acc_reg <= 48'h0;
         freq_lvl_reg <= 1'b0;
      end else if (freq_sum >= fdo_pkg::FREQ_HALF_THR) begin
         freq_acc_reg <= freq_sum - fdo_pkg::FREQ_HALF_THR;
         freq_lvl_reg <= !freq_lvl_reg;
      end else begin
         freq_acc_reg <= freq_sum;
      end
   end

   // Output select
   logic dout_next;

   always_comb begin
      dout_next = 1'b0;
      unique case (ctrl_reg.mode)
         fdo_pkg::MODE_OFF: dout_next = 1'b0;
         fdo_pkg::MODE_BINARY: dout_next = bin_level;
         fdo_pkg::MODE_PULSE: dout_next = (pstate_reg == fdo_pkg::P_HIGH);
         fdo_pkg::MODE_FREQ: dout_next = freq_lvl_reg;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dout_reg <= 1'b0;
      end else begin
         dout_reg <= dout_next;
      end
   end

   // Read path
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[fdo_pkg::ST_DOUT] = dout_reg;
      status_word[fdo_pkg::ST_REVERSE] = flow_reverse;
      status_word[fdo_pkg::ST_ALARM] = alarm_any;
      status_word[fdo_pkg::ST_BIN_LEVEL] = bin_level;
      status_word[fdo_pkg::ST_PULSE_BUSY] = (pstate_reg != fdo_pkg::P_IDLE);
      status_word[fdo_pkg::ST_PENDING_LSB +: 8] = pending_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= fdo_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_hit[6] ? fdo_pkg::RESP_SLVERR : fdo_pkg::RESP_OKAY;
         rdata_reg <= ({32{rd_hit[0]}} & {18'h0, ctrl_reg})
                    | ({32{rd_hit[1]}} & {24'h0, alarm_en_reg})
                    | ({32{rd_hit[2]}} & {16'h0, units_reg})
                    | ({32{rd_hit[3]}} & {16'h0, upper_freq_reg})
                    | ({32{rd_hit[4]}} & status_word)
                    | ({32{rd_hit[5]}} & pulse_total_reg);
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign dout = dout_reg;

endmodule

`default_nettype wire

// [dv/fdo_checker_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module fdo_checker #(
   parameter int PW_MAX_CYC = 8,
   parameter int TICK_HALF_CYC = 2
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Write path
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   // Plant side
   input wire logic flow_reverse,
   input wire fdo_pkg::fdo_alarm_t alarm_src,
   input wire logic range_two_active,
   input wire logic fill_reached,
   input wire logic dout
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Shadow lags a cycle; checks wait until settled
   logic [7:0] aw_reg, en_reg;
   logic [31:0] w_reg;
   logic [15:0] un_reg;
   logic [3:0] age_reg;
   logic bv_reg, quiet, mis, bin, pul;
   fdo_pkg::fdo_ctrl_t c_reg;
   int hi_reg, u, w_exp;
   assign quiet = age_reg > 4'h3 && !s_axi_bvalid;
   assign bin = quiet && c_reg.mode == fdo_pkg::MODE_BINARY;
   assign pul = quiet && c_reg.mode == fdo_pkg::MODE_PULSE;
   assign mis = (c_reg.dir == fdo_pkg::DIR_FWD && flow_reverse) || (c_reg.dir == fdo_pkg::DIR_REV && !flow_reverse);
   assign u = (un_reg == 16'h0) ? 1 : int'(un_reg);
   assign w_exp = (u * TICK_HALF_CYC > PW_MAX_CYC) ? PW_MAX_CYC : u * TICK_HALF_CYC;
   always_ff @(posedge sys_clk) begin
      bv_reg <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_reg <= s_axi_wdata;
      if (!rst_n) begin
         c_reg <= fdo_pkg::fdo_ctrl_t'(fdo_pkg::CTRL_RST);
         en_reg <= fdo_pkg::ALARM_EN_RST;
         un_reg <= fdo_pkg::UNITS_RST;
         age_reg <= 4'h0;
      end else if (s_axi_bvalid && !bv_reg && s_axi_bresp == fdo_pkg::RESP_OKAY) begin
         if (aw_reg == fdo_pkg::REG_CTRL) c_reg <= fdo_pkg::fdo_ctrl_t'(w_reg[13:0]);
         if (aw_reg == fdo_pkg::REG_ALARM_EN) en_reg <= w_reg[7:0];
         if (aw_reg == fdo_pkg::REG_UNITS) un_reg <= w_reg[15:0];
         age_reg <= 4'h0;
      end else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
   end
   always_ff @(posedge sys_clk) begin
      hi_reg <= (!rst_n || !dout) ? 0 : hi_reg + 1;
   end
   property p_off_idle; quiet && c_reg.mode == fdo_pkg::MODE_OFF |-> !dout; endproperty
   a_off_idle: assert property (p_off_idle) else $error("off not idle");
   property p_bin_dir; bin && c_reg.fn == fdo_pkg::FN_DIRECTION
      |=> dout == ($past(flow_reverse) ^ c_reg.pol_low); endproperty
   a_bin_dir: assert property (p_bin_dir) else $error("dir level");
   property p_bin_alarm; bin && c_reg.fn == fdo_pkg::FN_ALARM
      |=> dout == ((|($past(alarm_src) & en_reg)) ^ c_reg.pol_low); endproperty
   a_bin_alarm: assert property (p_bin_alarm) else $error("alarm level");
   property p_bin_range; bin && c_reg.fn == fdo_pkg::FN_RANGE
      |=> dout == (($past(range_two_active) & c_reg.dual_range) ^ c_reg.pol_low); endproperty
   a_bin_range: assert property (p_bin_range) else $error("range level");
   property p_bin_batch; bin && c_reg.fn == fdo_pkg::FN_BATCH
      |=> dout == (($past(fill_reached) & c_reg.batch_en) ^ c_reg.pol_low); endproperty
   a_bin_batch: assert property (p_bin_batch) else $error("batch level");
   property p_src_off; pul && c_reg.pulse_src[0] == c_reg.pulse_src[1] |-> !$rose(dout); endproperty
   a_src_off: assert property (p_src_off) else $error("pulse, source off");
   property p_width; pul && $fell(dout) |-> hi_reg == w_exp; endproperty
   a_width: assert property (p_width) else $error("pulse width");
   property p_freq_dir; (quiet && c_reg.mode == fdo_pkg::MODE_FREQ && mis) [*4] |-> $stable(dout); endproperty
   a_freq_dir: assert property (p_freq_dir) else $error("freq against filter");
endmodule
bind fdo_top fdo_checker #(.PW_MAX_CYC(PW_MAX_CYC), .TICK_HALF_CYC(TICK_HALF_CYC)) u_fdo_checker (
   .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .flow_reverse, .alarm_src, .range_two_active, .fill_reached, .dout);
`default_nettype wire

// [dv/fdo_plant_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module fdo_plant_counter (
   // Clock and terminal
   input wire logic clk,
   input wire logic contact,
   input wire logic clear,
   // Observed counts
   output int rises,
   output int width
);
   logic last = 1'h0;
   int run = 0;
   initial {rises, width} = 64'h0;
   // Plant sees only edges and closed time
   always @(posedge clk) begin
      last <= contact;
      if (clear) rises <= 0;
      else if (contact && !last) rises <= rises + 1;
      if (contact) run <= run + 1;
      else run <= 0;
      if (!contact && last) width <= run;
   end
endmodule
`default_nettype wire

// [dv/fdo_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fdo_top_tb_top;
   localparam int PW = 8;
   localparam int TH = 2;
   localparam int WIN = 4000;
   logic sys_clk = 1'h0, rst_n = 1'h0, clr = 1'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dout;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] mass_rate = 16'h0, volume_rate = 16'h0;
   logic mass_tick = 1'h0, volume_tick = 1'h0, flow_reverse = 1'h0, range_two_active = 1'h0, fill_reached = 1'h0;
   fdo_pkg::fdo_alarm_t alarm_src = 8'h0;
   int rises, width, fail_count = 0, check_count = 0, seed = 32'h3dd8;
   int m_ctrl = 0, m_en = 0, cnt, base, u, e;
   logic [2:0] r;
   longint rate;

   always #20 sys_clk = ~sys_clk;

   fdo_top #(.PW_MAX_CYC(PW), .TICK_HALF_CYC(TH)) u_fdo_top (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .mass_rate, .volume_rate, .mass_tick, .volume_tick, .flow_reverse, .alarm_src,
      .range_two_active, .fill_reached, .dout);
   fdo_plant_counter u_fdo_plant_counter (.clk(sys_clk), .contact(dout), .clear(clr), .rises(rises), .width(width));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic guard(input int n);
      if (n >= 64) begin
         fail_count++;
         report_and_stop();
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         n++;
      end while (!s_axi_bvalid && n < 64);
      s_axi_bready <= 1'h0;
      rs = s_axi_bresp;
      guard(n);
   endtask
   task automatic axi_read(input logic [7:0] a);
      int n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         n++;
      end while (!s_axi_rvalid && n < 64);
      s_axi_rready <= 1'h0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      guard(n);
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      axi_write(a, d);
      check(rs, a > fdo_pkg::REG_UPPER_FREQ ? fdo_pkg::RESP_SLVERR : fdo_pkg::RESP_OKAY);
      if (a == fdo_pkg::REG_CTRL) m_ctrl = d & 32'h3fff;
      if (a == fdo_pkg::REG_ALARM_EN) m_en = d & 32'hff;
   endtask
   task automatic rd_chk(input logic [7:0] a, input int exp, input logic [1:0] er);
      axi_read(a);
      check(rd, exp);
      check(rs, er);
   endtask
   function automatic logic bin_exp();
      logic lvl;
      case ((m_ctrl >> 8) & 7)
         1: lvl = flow_reverse;
         2: lvl = |(alarm_src & m_en[7:0]);
         3: lvl = range_two_active & m_ctrl[12];
         4: lvl = fill_reached & m_ctrl[13];
         default: lvl = 1'h0;
      endcase
      return lvl ^ m_ctrl[11];
   endfunction

   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'h1;
      check(dout, 1'h0);
      rd_chk(fdo_pkg::REG_CTRL, 0, fdo_pkg::RESP_OKAY);
      rd_chk(fdo_pkg::REG_ALARM_EN, fdo_pkg::ALARM_EN_RST, fdo_pkg::RESP_OKAY);
      rd_chk(fdo_pkg::REG_UNITS, fdo_pkg::UNITS_RST, fdo_pkg::RESP_OKAY);
      rd_chk(fdo_pkg::REG_UPPER_FREQ, fdo_pkg::UPPER_FREQ_RST, fdo_pkg::RESP_OKAY);
      rd_chk(8'h3c, 0, fdo_pkg::RESP_SLVERR);
      wr(fdo_pkg::REG_STATUS, 32'hffffffff);
      // Binary: filter and pulse bits must be ignored
      for (int fn = 0; fn < 5; fn++) begin
         for (int k = 0; k < 16; k++) begin
            if (k % 8 == 0) begin
               wr(fdo_pkg::REG_ALARM_EN, $random(seed));
               wr(fdo_pkg::REG_CTRL, 32'h1 | (fn << 8) | ($random(seed) & 32'h38fc));
               rd_chk(fdo_pkg::REG_CTRL, m_ctrl, fdo_pkg::RESP_OKAY);
            end
            @(posedge sys_clk);
            {mass_tick, volume_tick, flow_reverse, range_two_active, fill_reached} <= 5'($random(seed));
            alarm_src <= 8'($random(seed));
            repeat (2) @(posedge sys_clk);
            check(dout, bin_exp());
         end
      end
      {mass_tick, volume_tick} <= 2'h0;
      // Pulse: every source and filter
      for (int s = 0; s < 3; s++) begin
         for (int d = 0; d < 3; d++) begin
            u = 1 + (s * 3 + d) % 4;
            cnt = 0;
            wr(fdo_pkg::REG_CTRL, 32'h0);
            wr(fdo_pkg::REG_UNITS, u);
            wr(fdo_pkg::REG_CTRL, 32'h2 | (d << 2) | (((s + 1) % 3) << 4));
            axi_read(fdo_pkg::REG_PULSE_TOTAL);
            base = rd;
            clr <= 1'h1;
            @(posedge sys_clk);
            clr <= 1'h0;
            for (int t = 0; t < 7; t++) begin
               @(posedge sys_clk);
               r = 3'($random(seed));
               {mass_tick, volume_tick, flow_reverse} <= r;
               if (((s == 0 && r[2]) || (s == 1 && r[1])) && (d == 0 || (d == 1) != r[0])) cnt++;
               @(posedge sys_clk);
               {mass_tick, volume_tick} <= 2'h0;
               repeat (18) @(posedge sys_clk);
            end
            repeat (200) @(posedge sys_clk);
            check(rises, cnt / u);
            axi_read(fdo_pkg::REG_PULSE_TOTAL);
            check(rd - base, cnt / u);
            if (cnt >= u) check(width, u * TH > PW ? PW : u * TH);
         end
      end
      // Frequency: edges per window vs rate
      wr(fdo_pkg::REG_UPPER_FREQ, 32'hffff);
      mass_rate <= 16'hffff;
      volume_rate <= 16'h8000;
      for (int s = 0; s < 3; s++) begin
         for (int d = 0; d < 3; d++) begin
            r = 3'($random(seed));
            flow_reverse <= r[0];
            wr(fdo_pkg::REG_CTRL, 32'h0);
            wr(fdo_pkg::REG_CTRL, 32'h3 | (d << 2) | (s << 6));
            rate = (s == 1) ? 65535 : (s == 2) ? 32768 : 0;
            if (d == 1 && r[0] || d == 2 && !r[0]) rate = 0;
            e = int'(rate * 65535 * WIN / (longint'(fdo_pkg::CLK_HZ) * 65536));
            clr <= 1'h1;
            @(posedge sys_clk);
            clr <= 1'h0;
            repeat (WIN) @(posedge sys_clk);
            check(e == 0 ? rises == 0 : rises >= e - 1 && rises <= e + 1, 1'h1);
         end
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
